// ===== fault_log_keeper.sv
// Fault record store with source tagging and timed erase
`timescale 1ns/10ps
`default_nettype none
module fault_log_keeper
   import fault_log_pkg::*;
#(
   parameter int DEPTH        = LOG_DEPTH,
   parameter int ERASE_CNT    = ERASE_CYCLES
)
(
   input  wire logic                 SYS_CLK,
   input  wire logic                 SYS_RST,
   input  wire logic [FLT_KINDS-1:0] FAULT_CH0,
   input  wire logic [FLT_KINDS-1:0] FAULT_CH1,
   input  wire logic                 SAVE_REQ,
   input  wire logic                 ERASE_REQ,
   input  wire logic [LOG_IDX_W-1:0] RD_IDX,
   output logic [7:0]                RD_CODE,
   output logic                      RD_VALID,
   output logic [7:0]                VENDOR_STATUS,
   output logic                      ERASE_BUSY
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                      ev_valid;
   logic [7:0]                ev_code;
   logic [7:0]                code_reg   [DEPTH];
   logic [7:0]                code_next  [DEPTH];
   logic [DEPTH-1:0]          valid_reg;
   logic [DEPTH-1:0]          valid_next;
   logic [LOG_IDX_W-1:0]      wr_ptr_reg;
   logic [LOG_IDX_W-1:0]      wr_ptr_next;
   erase_state_t              state_reg;
   erase_state_t              state_next;
   logic [ERASE_CNT_W-1:0]    cnt_reg;
   logic [ERASE_CNT_W-1:0]    cnt_next;
   logic [7:0]                vstat_reg;
   logic [7:0]                vstat_next;
   logic [7:0]                rd_code_reg;
   logic                      rd_valid_reg;
   logic                      busy_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Source encoder
   fault_src_encoder u_enc (
      .fault_ch0   (FAULT_CH0),
      .fault_ch1   (FAULT_CH1),
      .save_req    (SAVE_REQ),
      .event_valid (ev_valid),
      .event_code  (ev_code)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Erase sequencer and store update
   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      code_next   = code_reg;
      valid_next  = valid_reg;
      wr_ptr_next = wr_ptr_reg;
      vstat_next  = vstat_reg;
      case (state_reg)
         ST_IDLE: begin
            if (ERASE_REQ) begin
               state_next = ST_WIPE;
            end else if (ev_valid) begin
               code_next[wr_ptr_reg]  = ev_code;
               valid_next[wr_ptr_reg] = 1'b1;
               wr_ptr_next = (wr_ptr_reg == LOG_IDX_W'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
               vstat_next[LOG_PRESENT_BIT] = 1'b1;
            end
         end
         ST_WIPE: begin
            for (int i = 0; i < DEPTH; i++) begin
               code_next[i] = 8'h00;
            end
            valid_next  = '0;
            wr_ptr_next = '0;
            // One wipe cycle plus ERASE_CNT-1 counted cycles keeps the clear inside the bound
            cnt_next    = ERASE_CNT_W'(ERASE_CNT - 2);
            state_next  = ST_WAIT;
         end
         ST_WAIT: begin
            // flag clears at the end of the erase window
            if (cnt_reg == '0) begin
               vstat_next[LOG_PRESENT_BIT] = 1'b0;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // Faults arriving mid-erase are dropped: the store is being wiped anyway
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg  <= ST_IDLE;
         cnt_reg    <= '0;
         valid_reg  <= '0;
         wr_ptr_reg <= '0;
         vstat_reg  <= VSTAT_RESET;
         for (int i = 0; i < DEPTH; i++) begin
            code_reg[i] <= 8'h00;
         end
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         valid_reg  <= valid_next;
         wr_ptr_reg <= wr_ptr_next;
         vstat_reg  <= vstat_next;
         code_reg   <= code_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered read port; out of range index reads as empty
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         rd_code_reg  <= 8'h00;
         rd_valid_reg <= 1'b0;
         busy_reg     <= 1'b0;
      end else begin
         rd_code_reg  <= (int'(RD_IDX) < DEPTH) ? code_reg[RD_IDX] : 8'h00;
         rd_valid_reg <= (int'(RD_IDX) < DEPTH) ? valid_reg[RD_IDX] : 1'b0;
         busy_reg     <= (state_next != ST_IDLE);
      end
   end

   assign RD_CODE       = rd_code_reg;
   assign RD_VALID      = rd_valid_reg;
   assign VENDOR_STATUS = vstat_reg;
   assign ERASE_BUSY    = busy_reg;

endmodule // fault_log_keeper
`default_nettype wire

// ===== fault_log_pkg.sv
// Package with constants and types for the fault record bookkeeping block
// Functional notes
// - Each stored record carries a source code; 0xff means host save request.
// - Erase command wipes every value held in the fault record store.
// - Erase command also clears bit 3 of the vendor status byte.
// - Status flag may take up to 8 ms to clear after erase.
package fault_log_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Source codes
   localparam logic [7:0] SRC_SAVE_REQ      = 8'hff;
   localparam logic [7:0] SRC_TURN_ON_TMO   = 8'h00;
   localparam logic [7:0] SRC_OUT_OV        = 8'h01;
   localparam logic [7:0] SRC_OUT_UV        = 8'h02;
   localparam logic [7:0] SRC_OUT_OC        = 8'h03;
   localparam logic [7:0] SRC_OVER_TEMP     = 8'h05;
   localparam logic [7:0] SRC_UNDER_TEMP    = 8'h06;
   localparam logic [7:0] SRC_IN_OV         = 8'h07;
   localparam logic [7:0] SRC_DIE_OVERTEMP  = 8'h0a;
   localparam logic [7:0] SRC_CHAN1_OFFSET  = 8'h10;

   // Fault vector bit positions, one bit per fault kind
   localparam int FLT_TURN_ON_TMO  = 0;
   localparam int FLT_OUT_OV       = 1;
   localparam int FLT_OUT_UV       = 2;
   localparam int FLT_OUT_OC       = 3;
   localparam int FLT_OVER_TEMP    = 4;
   localparam int FLT_UNDER_TEMP   = 5;
   localparam int FLT_IN_OV        = 6;
   localparam int FLT_DIE_OVERTEMP = 7;
   localparam int FLT_KINDS        = 8;

   // Vendor status byte
   localparam int         LOG_PRESENT_BIT   = 3;
   localparam logic [7:0] VSTAT_RESET       = 8'h00;

   // Erase latency
   localparam int CLK_FREQ_HZ     = 20000000;
   localparam int ERASE_TIME_US   = 8000;
   localparam int ERASE_CYCLES    = (CLK_FREQ_HZ / 1000000) * ERASE_TIME_US;
   localparam int ERASE_CNT_W     = 18;

   // Store geometry
   localparam int LOG_DEPTH       = 6;
   localparam int LOG_IDX_W       = 3;

   typedef enum logic [1:0] {ST_IDLE, ST_WIPE, ST_WAIT} erase_state_t;

endpackage : fault_log_pkg

// ===== fault_src_encoder.sv
// Priority encoder from per-channel fault strobes to a record source code
`timescale 1ns/10ps
`default_nettype none
module fault_src_encoder
   import fault_log_pkg::*;
(
   input  wire logic [FLT_KINDS-1:0] fault_ch0,
   input  wire logic [FLT_KINDS-1:0] fault_ch1,
   input  wire logic                 save_req,
   output logic                      event_valid,
   output logic [7:0]                event_code
);

   ////////////////////////////////////////////////////////////////////////////
   // Map one fault position to its channel 0 code
   function automatic logic [7:0] base_code(input int pos);
      case (pos)
         FLT_TURN_ON_TMO:  base_code = SRC_TURN_ON_TMO;
         FLT_OUT_OV:       base_code = SRC_OUT_OV;
         FLT_OUT_UV:       base_code = SRC_OUT_UV;
         FLT_OUT_OC:       base_code = SRC_OUT_OC;
         FLT_OVER_TEMP:    base_code = SRC_OVER_TEMP;
         FLT_UNDER_TEMP:   base_code = SRC_UNDER_TEMP;
         FLT_IN_OV:        base_code = SRC_IN_OV;
         default:          base_code = SRC_DIE_OVERTEMP;
      endcase
   endfunction

   // Lowest fault bit wins, channel 0 ahead of channel 1; host save last
   always_comb begin
      event_valid = 1'b0;
      event_code  = SRC_SAVE_REQ;
      if (save_req) begin
         event_valid = 1'b1;
         event_code  = SRC_SAVE_REQ;
      end
      for (int i = FLT_KINDS-1; i >= 0; i--) begin
         if (fault_ch1[i]) begin
            event_valid = 1'b1;
            event_code  = base_code(i) + SRC_CHAN1_OFFSET;
         end
      end
      for (int i = FLT_KINDS-1; i >= 0; i--) begin
         if (fault_ch0[i]) begin
            event_valid = 1'b1;
            event_code  = base_code(i);
         end
      end
   end

endmodule // fault_src_encoder
`default_nettype wire

// ===== fault_log_chk.sv
// Port checker for the fault record keeper
`timescale 1ns/10ps
`default_nettype none
module fault_log_chk
   import fault_log_pkg::*;
#(
   parameter int ERASE_CNT = ERASE_CYCLES
)
(
   input wire logic                 SYS_CLK,
   input wire logic                 SYS_RST,
   input wire logic [FLT_KINDS-1:0] FAULT_CH0,
   input wire logic                 SAVE_REQ,
   input wire logic                 ERASE_REQ,
   input wire logic                 RD_VALID,
   input wire logic [7:0]           VENDOR_STATUS,
   input wire logic                 ERASE_BUSY
);
   localparam int DM = ERASE_CNT;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // Erase only counts when taken in idle
   wire idle_erase = ERASE_REQ && !ERASE_BUSY;
   wire idle_take = !ERASE_BUSY && !ERASE_REQ;
   // Busy length counter; the window is far too long for a plain delay
   int busy_cnt;
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         busy_cnt <= 0;
      end else if (ERASE_BUSY) begin
         busy_cnt <= busy_cnt + 1;
      end else begin
         busy_cnt <= 0;
      end
   end
   ////////////////////////////////////////
   log_set_a: assert property (idle_take && |FAULT_CH0 |=> VENDOR_STATUS[3])
      else $error("fault did not set log flag");
   save_set_a: assert property (idle_take && SAVE_REQ |=> VENDOR_STATUS[3])
      else $error("save did not set log flag");
   wipe_read_a: assert property (idle_erase |-> ##3 !RD_VALID)
      else $error("record survived erase");
   stat_bits_a: assert property (VENDOR_STATUS[7:4] == 4'h0 && VENDOR_STATUS[2:0] == 3'h0)
      else $error("stray status bit");
   busy_rise_a: assert property (idle_erase |=> ERASE_BUSY)
      else $error("erase did not raise busy");
   flag_time_a: assert property ($fell(ERASE_BUSY) |-> busy_cnt == DM)
      else $error("erase window length wrong");
   busy_limit_a: assert property (ERASE_BUSY |-> busy_cnt < DM)
      else $error("erase window overran");
   busy_end_a: assert property ($fell(ERASE_BUSY) |-> !VENDOR_STATUS[3])
      else $error("busy ended with flag set");
endmodule // fault_log_chk
bind fault_log_keeper fault_log_chk #(.ERASE_CNT(ERASE_CNT)) chk_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
   .FAULT_CH0(FAULT_CH0), .SAVE_REQ(SAVE_REQ), .ERASE_REQ(ERASE_REQ), .RD_VALID(RD_VALID),
   .VENDOR_STATUS(VENDOR_STATUS), .ERASE_BUSY(ERASE_BUSY));
`default_nettype wire

// ===== fault_host_model.sv
// Host model issuing save and erase commands
`timescale 1ns/10ps
`default_nettype none
module fault_host_model (
   input  wire logic clk,
   output var logic  save_req,
   output var logic  erase_req
);
   initial begin
      save_req = 1'b0;
      erase_req = 1'b0;
   end
   ////////////////////////////////////////
   // send-byte only
   // A decoded command is one clock wide; there is no data or read phase
   task automatic send_save();
      @(posedge clk);
      #1 save_req = 1'b1;
      @(posedge clk);
      #1 save_req = 1'b0;
   endtask
   task automatic send_erase();
      @(posedge clk);
      #1 erase_req = 1'b1;
      @(posedge clk);
      #1 erase_req = 1'b0;
   endtask
endmodule // fault_host_model
`default_nettype wire

// ===== tb_fault_log_keeper.sv
// Self-checking bench for the fault record keeper
`timescale 1ns/10ps
`default_nettype none
module tb_fault_log_keeper;
   localparam int EC = 20; // Short erase count keeps the run brief
   localparam logic [7:0] CODE [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0a};
   logic clk, rst, save, erase, vld, busy;
   logic [7:0] f0, f1, code, vstat;
   logic [2:0] idx, wp;
   int error_cnt, samples_checked;
   fault_host_model fault_host_model_inst (.clk(clk), .save_req(save), .erase_req(erase));
   fault_log_keeper #(.ERASE_CNT(EC)) fault_log_keeper_inst (.SYS_CLK(clk), .SYS_RST(rst),
      .FAULT_CH0(f0), .FAULT_CH1(f1), .SAVE_REQ(save), .ERASE_REQ(erase), .RD_IDX(idx),
      .RD_CODE(code), .RD_VALID(vld), .VENDOR_STATUS(vstat), .ERASE_BUSY(busy));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] a);
      samples_checked++;
      if (a !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, a);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One record in, then read back from the slot it should occupy
   task automatic rec(input logic [7:0] a, input logic [7:0] b, input logic s, input logic [7:0] e);
      if (s) fault_host_model_inst.send_save();
      else begin
         @(posedge clk);
         #1 f0 = a; f1 = b;
         @(posedge clk);
         #1 f0 = 8'h00; f1 = 8'h00;
      end
      idx = wp;
      repeat (3) @(posedge clk);
      #1 chk("code", e, code);
      chk("valid", 8'h01, {7'h00, vld});
      wp = (wp == 3'h5) ? 3'h0 : wp + 3'h1;
   endtask
   task automatic t_codes();
      for (int i = 0; i < 8; i++) begin
         rec(8'h01 << i, 8'h00, 1'b0, CODE[i]);
         rec(8'h00, 8'h01 << i, 1'b0, CODE[i] | 8'h10);
      end
      rec(8'h00, 8'h00, 1'b1, 8'hff);
      rec(8'h84, 8'h01, 1'b0, 8'h02);
      rec(8'h00, 8'h06, 1'b0, 8'h11);
      chk("status", 8'h08, vstat);
      // Index beyond the ring reads as empty
      idx = 3'h6;
      repeat (2) @(posedge clk);
      #1 chk("empty_valid", 8'h00, {7'h00, vld});
      chk("empty_code", 8'h00, code);
      $display("test codes done");
   endtask
   // host waits full latency; a fault mid-erase is dropped
   task automatic t_erase();
      idx = 3'h0;
      fault_host_model_inst.send_erase();
      @(posedge clk);
      #1 chk("busy", 8'h01, {7'h00, busy});
      f0 = 8'h01;
      @(posedge clk);
      #1 f0 = 8'h00;
      @(posedge clk);
      #1 chk("wiped", 8'h00, {7'h00, vld});
      repeat (EC - 4) @(posedge clk);
      #1 chk("status", 8'h08, vstat);
      chk("busy", 8'h01, {7'h00, busy});
      @(posedge clk);
      #1 chk("status", 8'h00, vstat);
      chk("busy", 8'h00, {7'h00, busy});
      chk("dropped", 8'h00, {7'h00, vld});
      chk("wiped_code", 8'h00, code);
      $display("test erase done");
   endtask
   initial begin
      {f0, f1, idx, wp, error_cnt, samples_checked} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      t_codes();
      t_erase();
      end_sim();
   end
   // Watchdog: the tests need some 120 cycles
   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end
endmodule // tb_fault_log_keeper
`default_nettype wire
